// ### shared/sfc_map.svh
/*
  Constant map of the serial-flash configuration reader: read opcodes,
  field widths, bit counts and clock figures. Assumes a 100 MHz core clock.
*/
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

`define SFC_OP_FAST_X1    8'h0B
`define SFC_OP_FAST_X2    8'h3B
`define SFC_OP_FAST_X4    8'h6B
`define SFC_OP_FAST_X1_W  8'h0C
`define SFC_OP_FAST_X2_W  8'h3C
`define SFC_OP_FAST_X4_W  8'h6C

`define SFC_CMD_BITS      6'h08
`define SFC_ADDR_N_BITS   6'h18
`define SFC_ADDR_W_BITS   6'h20
`define SFC_DUMMY_CLKS    6'h08
`define SFC_GAP_TICKS     6'h04
`define SFC_PAD_BYTE      8'h00
`define SFC_START_ADDR    32'h0000_0000
`define SFC_ADDR_STEP     32'h0000_0001

`define SFC_CORE_CLK_KHZ  100000
`define SFC_BOOT_CLK_KHZ  3000
`define SFC_BOOT_HALF \
  8'((`SFC_CORE_CLK_KHZ) / (2 * `SFC_BOOT_CLK_KHZ))

`endif

// ### shared/sfc_pkg.sv
/*
  Types of the serial-flash configuration reader: states, widths, command
  strobes from the bitstream decoder, pin bundle and module state records.
  Assumes sfc_map.svh holds all numeric constants.
*/
package sfc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA  = 3'b100,
    ST_GAP   = 3'b101,
    ST_DONE  = 3'b110
  } sfc_state_t;

  typedef enum logic [1:0] {
    W_X1 = 2'b00,
    W_X2 = 2'b01,
    W_X4 = 2'b10
  } sfc_width_t;

  typedef struct packed {
    logic       width_vld;
    sfc_width_t width;
    logic       fall_edge;
    logic       ext_clk;
    logic       rate_vld;
    logic [7:0] rate;
  } sfc_cmd_t;

  typedef struct packed {
    logic config_serial_clk;
    logic flash_select_n;
    logic data0_out_line;
    logic data0_oe_n;
    logic data0_pullup;
  } sfc_flash_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } sfc_byte_t;

  typedef struct packed {
    sfc_state_t st;
    sfc_width_t width;
    sfc_width_t pend_w;
    logic       pend;
    logic       wide;
    logic       fall;
    logic       ext;
    logic       rate_vld;
    logic [7:0] rate;
    logic       run;
    sfc_flash_t flash;
    logic [39:0] sr;
    logic [5:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [31:0] addr;
    sfc_byte_t  obyte;
    logic       chain;
    logic       chain_en;
    logic [3:0] dq_s1;
    logic [3:0] dq_s2;
    logic       strap_s1;
    logic       strap_s2;
  } sfc_st_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } sfc_div_t;

  typedef struct packed {
    logic rst1;
    logic rst2;
    logic tog;
  } sfc_xsrc_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sfc_xdst_t;

endpackage

// ### verilog/sfc_rate_div.sv
/*
  Tick generator on the core clock: one pulse every i_half cycles.
  Assumes i_half is at least 4 so pin synchronisers keep up.
*/
`timescale 1ns/100ps
`default_nettype none
module sfc_rate_div (
  input  wire logic       i_core_clk,
  input  wire logic       i_srst,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  output logic            o_tick
);
  sfc_pkg::sfc_div_t q_ff;
  sfc_pkg::sfc_div_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.tick = 1'b0;
    if (!i_run) begin
      nxt_q.cnt = '0;
    end else if (8'(q_ff.cnt + 8'h01) >= i_half) begin
      nxt_q.cnt = '0;
      nxt_q.tick = 1'b1;
    end else begin
      nxt_q.cnt = 8'(q_ff.cnt + 8'h01);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_tick = q_ff.tick;
endmodule // sfc_rate_div
`default_nettype wire

// ### verilog/sfc_ext_tick.sv
/*
  Turns rising edges of the external master clock into core-clock ticks.
  A toggle on the external clock crosses by a two-flop synchroniser.
  Assumes the external clock runs while reset is held.
*/
`timescale 1ns/100ps
`default_nettype none
module sfc_ext_tick (
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_external_master_clk_in,
  output logic      o_tick
);
  sfc_pkg::sfc_xsrc_t x_ff;
  sfc_pkg::sfc_xsrc_t nxt_x;
  sfc_pkg::sfc_xdst_t c_ff;
  sfc_pkg::sfc_xdst_t nxt_c;

  // Reset reaches the external domain only through its own synchroniser
  always_comb begin
    nxt_x = x_ff;
    nxt_x.rst1 = i_srst;
    nxt_x.rst2 = x_ff.rst1;
    nxt_x.tog = x_ff.rst2 ? 1'b0 : ~x_ff.tog;
  end

  always_ff @(posedge i_external_master_clk_in) begin
    x_ff <= nxt_x;
  end

  always_comb begin
    nxt_c = c_ff;
    nxt_c.s1 = x_ff.tog;
    nxt_c.s2 = c_ff.s1;
    nxt_c.s3 = c_ff.s2;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      c_ff <= '0;
    end else begin
      c_ff <= nxt_c;
    end
  end

  // Edge taken behind the second stage, from s2 against s3
  assign o_tick = c_ff.s2 ^ c_ff.s3;
endmodule // sfc_ext_tick
`default_nettype wire

// ### verilog/sfc_flash_loader.sv
/*
  Serial-flash configuration reader: drives clock, select and data0 of an
  external flash, sends fast-read command and address, and assembles the
  returned bitstream into bytes at x1, x2 or x4 width.
  Assumes a bitstream decoder on the core clock that returns one-cycle
  command strobes on i_cmd, and a flash that shifts data on falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.svh"
module sfc_flash_loader (
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  input  wire logic              i_external_master_clk_in,
  input  wire logic [3:0]        i_flash_dq,
  input  wire logic              i_config_pullup_strap_n,
  input  wire logic              i_wide_address_option,
  input  wire sfc_pkg::sfc_cmd_t i_cmd,
  input  wire logic              i_cfg_done,
  output var sfc_pkg::sfc_flash_t o_flash,
  output var sfc_pkg::sfc_byte_t  o_byte,
  output logic                   o_chain_data,
  output logic                   o_chain_en
);
  sfc_pkg::sfc_st_t q_ff;
  sfc_pkg::sfc_st_t nxt_q;

  logic        div_tick;
  logic        ext_tick;
  logic        tick;
  logic        rise;
  logic        fall_e;
  logic        smp;
  logic        div_run;
  logic [7:0]  half;
  logic [5:0]  total;
  logic [3:0]  sum;
  logic [7:0]  asm_byte;
  logic [7:0]  op;
  logic [39:0] ld;

  function automatic logic [7:0] sfc_opcode(
    input sfc_pkg::sfc_width_t w,
    input logic                wide
  );
    case (w)
      sfc_pkg::W_X2: sfc_opcode = wide ? `SFC_OP_FAST_X2_W
                                       : `SFC_OP_FAST_X2;
      sfc_pkg::W_X4: sfc_opcode = wide ? `SFC_OP_FAST_X4_W
                                       : `SFC_OP_FAST_X4;
      default:       sfc_opcode = wide ? `SFC_OP_FAST_X1_W
                                       : `SFC_OP_FAST_X1;
    endcase
  endfunction

  sfc_rate_div u_div (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_run      (div_run),
    .i_half     (half),
    .o_tick     (div_tick)
  );

  sfc_ext_tick u_ext (
    .i_core_clk               (i_core_clk),
    .i_srst                   (i_srst),
    .i_external_master_clk_in (i_external_master_clk_in),
    .o_tick                   (ext_tick)
  );

  // Clock source and rate
  assign tick = q_ff.ext ? ext_tick : div_tick;
  // Boot rate holds until the first byte is in, so command setup keeps its margin
  assign half = (q_ff.run & q_ff.rate_vld) ? q_ff.rate
                                           : `SFC_BOOT_HALF;
  assign div_run = (q_ff.st == sfc_pkg::ST_SHIFT) |
                   (q_ff.st == sfc_pkg::ST_DUMMY) |
                   (q_ff.st == sfc_pkg::ST_DATA)  |
                   (q_ff.st == sfc_pkg::ST_GAP);
  assign rise   = tick & ~q_ff.flash.config_serial_clk;
  assign fall_e = tick & q_ff.flash.config_serial_clk;
  assign smp    = q_ff.fall ? fall_e : rise;

  // Command framing
  assign total = q_ff.wide ? 6'(`SFC_CMD_BITS + `SFC_ADDR_W_BITS)
                           : 6'(`SFC_CMD_BITS + `SFC_ADDR_N_BITS);
  assign op = sfc_opcode(q_ff.width, q_ff.wide);
  // Flash must accept 32-bit reads from 24-bit boot mode
  assign ld = q_ff.wide ? {op, q_ff.addr}
                        : {op, q_ff.addr[23:0], `SFC_PAD_BYTE};

  // Bit assembly, most significant lane first
  assign sum = 4'({1'b0, q_ff.bitn} + (4'h1 << q_ff.width));
  always_comb begin
    case (q_ff.width)
      sfc_pkg::W_X2: asm_byte = {q_ff.sh[5:0], q_ff.dq_s2[1:0]};
      sfc_pkg::W_X4: asm_byte = {q_ff.sh[3:0], q_ff.dq_s2};
      default:       asm_byte = {q_ff.sh[6:0], q_ff.dq_s2[1]};
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    nxt_q.obyte.vld = 1'b0;
    nxt_q.dq_s1 = i_flash_dq;
    nxt_q.dq_s2 = q_ff.dq_s1;
    nxt_q.strap_s1 = i_config_pullup_strap_n;
    nxt_q.strap_s2 = q_ff.strap_s1;
    nxt_q.flash.data0_pullup = ~q_ff.strap_s2;
    // Option flags are sticky until reset
    if (i_cmd.fall_edge) begin
      nxt_q.fall = 1'b1;
    end
    // Decoder is trusted to order the edge switch first
    if (i_cmd.ext_clk) begin
      nxt_q.ext = 1'b1;
    end
    if (i_cmd.rate_vld) begin
      nxt_q.rate_vld = 1'b1;
      nxt_q.rate = i_cmd.rate;
    end
    if (i_cmd.width_vld && (i_cmd.width != q_ff.width)) begin
      nxt_q.pend = 1'b1;
      nxt_q.pend_w = i_cmd.width;
    end
    case (q_ff.st)
      sfc_pkg::ST_IDLE: begin
        nxt_q.wide = i_wide_address_option;
        nxt_q.width = sfc_pkg::W_X1;
        nxt_q.st = sfc_pkg::ST_LOAD;
      end
      sfc_pkg::ST_LOAD: begin
        nxt_q.flash.flash_select_n = 1'b0;
        nxt_q.flash.data0_oe_n = 1'b0;
        nxt_q.flash.config_serial_clk = 1'b0;
        nxt_q.sr = ld;
        nxt_q.flash.data0_out_line = ld[39];
        nxt_q.cnt = '0;
        nxt_q.bitn = '0;
        nxt_q.st = sfc_pkg::ST_SHIFT;
      end
      sfc_pkg::ST_SHIFT: begin
        if (rise) begin
          nxt_q.flash.config_serial_clk = 1'b1;
          nxt_q.cnt = 6'(q_ff.cnt + 6'h01);
        end else if (fall_e) begin
          nxt_q.flash.config_serial_clk = 1'b0;
          if (q_ff.cnt == total) begin
            nxt_q.flash.data0_oe_n = 1'b1;
            nxt_q.cnt = '0;
            nxt_q.st = sfc_pkg::ST_DUMMY;
          end else begin
            nxt_q.sr = {q_ff.sr[38:0], 1'b0};
            nxt_q.flash.data0_out_line = q_ff.sr[38];
          end
        end
      end
      sfc_pkg::ST_DUMMY: begin
        if (rise) begin
          nxt_q.flash.config_serial_clk = 1'b1;
          nxt_q.cnt = 6'(q_ff.cnt + 6'h01);
        end else if (fall_e) begin
          nxt_q.flash.config_serial_clk = 1'b0;
          if (q_ff.cnt == `SFC_DUMMY_CLKS) begin
            nxt_q.st = sfc_pkg::ST_DATA;
          end
        end
      end
      sfc_pkg::ST_DATA: begin
        if (rise) begin
          nxt_q.flash.config_serial_clk = 1'b1;
        end else if (fall_e) begin
          nxt_q.flash.config_serial_clk = 1'b0;
        end
        if (smp) begin
          nxt_q.sh = asm_byte;
          nxt_q.bitn = sum[2:0];
          nxt_q.chain = q_ff.dq_s2[1];
          if (sum[3]) begin
            nxt_q.obyte.vld = 1'b1;
            nxt_q.obyte.data = asm_byte;
            nxt_q.addr = 32'(q_ff.addr + `SFC_ADDR_STEP);
            nxt_q.run = 1'b1;
            // Width changes only at a byte boundary; the new read
            // resumes at the next unread address
            if (q_ff.pend) begin
              nxt_q.cnt = '0;
              nxt_q.st = sfc_pkg::ST_GAP;
            end
          end
        end
      end
      sfc_pkg::ST_GAP: begin
        if (tick) begin
          if (q_ff.flash.config_serial_clk) begin
            nxt_q.flash.config_serial_clk = 1'b0;
          end else if (!q_ff.flash.flash_select_n) begin
            nxt_q.flash.flash_select_n = 1'b1;
          end else if (q_ff.cnt == `SFC_GAP_TICKS) begin
            nxt_q.width = q_ff.pend_w;
            nxt_q.pend = (nxt_q.pend_w != q_ff.pend_w); // New strobe wins
            nxt_q.st = sfc_pkg::ST_LOAD;
          end else begin
            nxt_q.cnt = 6'(q_ff.cnt + 6'h01);
          end
        end
      end
      sfc_pkg::ST_DONE: begin
        nxt_q.st = sfc_pkg::ST_DONE;
      end
      default: begin
        nxt_q.st = sfc_pkg::ST_IDLE;
      end
    endcase
    nxt_q.chain_en = (nxt_q.st == sfc_pkg::ST_DATA) &&
                     (nxt_q.width == sfc_pkg::W_X1);
    if (i_cfg_done) begin
      nxt_q.st = sfc_pkg::ST_DONE;
      nxt_q.flash.flash_select_n = 1'b1;
      nxt_q.flash.config_serial_clk = 1'b0;
      nxt_q.flash.data0_oe_n = 1'b1;
      nxt_q.chain_en = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      q_ff <= '0;
      q_ff.flash.flash_select_n <= 1'b1;
      q_ff.flash.data0_oe_n <= 1'b1;
      q_ff.addr <= `SFC_START_ADDR;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_flash      = q_ff.flash;
  assign o_byte       = q_ff.obyte;
  assign o_chain_data = q_ff.chain;
  assign o_chain_en   = q_ff.chain_en;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_cmd_end;
    (q_ff.st == sfc_pkg::ST_SHIFT) ##1 (q_ff.st == sfc_pkg::ST_DUMMY);
  endsequence

  sequence s_regap;
    (q_ff.st == sfc_pkg::ST_GAP) && tick && q_ff.flash.flash_select_n &&
    !q_ff.flash.config_serial_clk && (q_ff.cnt == `SFC_GAP_TICKS);
  endsequence

  property p_select;
    (q_ff.st == sfc_pkg::ST_LOAD) && !i_cfg_done
      |=> !o_flash.flash_select_n ##0 (q_ff.st == sfc_pkg::ST_SHIFT);
  endproperty
  a_select: assert property (p_select)
    else $error("select not low when command starts");

  property p_first_op;
    (q_ff.st == sfc_pkg::ST_IDLE) && !i_cfg_done ##1
    (q_ff.st == sfc_pkg::ST_LOAD) && !i_cfg_done
      |=> (q_ff.sr[39:32] == (q_ff.wide ? `SFC_OP_FAST_X1_W
                                        : `SFC_OP_FAST_X1));
  endproperty
  a_first_op: assert property (p_first_op)
    else $error("first read opcode wrong");

  property p_dual_op;
    (q_ff.st == sfc_pkg::ST_LOAD) && !i_cfg_done && !q_ff.wide &&
    (q_ff.width == sfc_pkg::W_X2) |=> (q_ff.sr[39:32] == `SFC_OP_FAST_X2);
  endproperty
  a_dual_op: assert property (p_dual_op)
    else $error("dual read opcode wrong");

  property p_quad_wide_op;
    (q_ff.st == sfc_pkg::ST_LOAD) && !i_cfg_done && q_ff.wide &&
    (q_ff.width == sfc_pkg::W_X4)
      |=> (q_ff.sr[39:32] == `SFC_OP_FAST_X4_W);
  endproperty
  a_quad_wide_op: assert property (p_quad_wide_op)
    else $error("quad wide read opcode wrong");

  property p_reissue;
    (s_regap and !i_cfg_done) |=> (q_ff.st == sfc_pkg::ST_LOAD)
      ##1 !o_flash.flash_select_n;
  endproperty
  a_reissue: assert property (p_reissue)
    else $error("no fresh read after width change");

  property p_release;
    s_cmd_end |-> o_flash.data0_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("data0 still driven after address");

  property p_rise_default;
    !q_ff.fall && fall_e && (q_ff.st == sfc_pkg::ST_DATA) && !i_cfg_done
      |=> (q_ff.bitn == $past(q_ff.bitn)) && !o_byte.vld;
  endproperty
  a_rise_default: assert property (p_rise_default)
    else $error("data taken on falling edge in rising mode");

  property p_fall_sticky;
    q_ff.fall |=> q_ff.fall;
  endproperty
  a_fall_sticky: assert property (p_fall_sticky)
    else $error("falling capture mode lost");

  property p_boot_rate;
    !(q_ff.run && q_ff.rate_vld) |-> (half == `SFC_BOOT_HALF);
  endproperty
  a_boot_rate: assert property (p_boot_rate)
    else $error("rate raised before read began");

  property p_ext_src;
    q_ff.ext |-> (tick == ext_tick);
  endproperty
  a_ext_src: assert property (p_ext_src)
    else $error("external clock not selected");

  property p_chain;
    o_chain_en |-> (q_ff.width == sfc_pkg::W_X1);
  endproperty
  a_chain: assert property (p_chain)
    else $error("chain output active in wide mode");

  property p_done;
    i_cfg_done |=> o_flash.flash_select_n && !o_flash.config_serial_clk;
  endproperty
  a_done: assert property (p_done)
    else $error("select not high after configuration");

  property p_byte_src;
    o_byte.vld |-> ($past(q_ff.st) == sfc_pkg::ST_DATA);
  endproperty
  a_byte_src: assert property (p_byte_src)
    else $error("byte emitted outside data phase");

endmodule // sfc_flash_loader
`default_nettype wire

// ### tb/sfc_flash_model.sv
/*
  Behavioural serial flash for the loader bench: fast-read opcodes, 24 or
  32-bit address, 8 dummy clocks, read data shifted on the falling clock.
  Assumes clock and select come straight from the loader pins.
*/
`timescale 1ns/100ps
`default_nettype none
module sfc_flash_model (
  input  wire logic  i_sclk,
  input  wire logic  i_sel_n,
  input  wire logic  i_d0,
  input  wire logic  i_d0_oe_n,
  input  wire logic  i_pullup,
  output logic [3:0] o_dq,
  output logic [7:0] o_op = 8'h00,
  output logic [31:0] o_addr = 32'h0,
  output int         o_loads = 0,
  output int         o_nbits = 0,
  output logic       o_clash = 1'h0
);
  logic [3:0]  fq = 4'h0;
  logic [3:0]  fe = 4'h0;
  logic [7:0]  cur = 8'h00;
  logic [31:0] ca = 32'h0;
  int          cnt = 0;
  int          bi = 0;
  int          w = 1;
  int          ab = 24;

  function automatic logic [7:0] mem(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  // Released lanes show the inverse of their last value; released data0 shows the loader's bit or the pull-up first
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_dq[i] = fe[i] ? fq[i] : ~fq[i];
    end
    if (!fe[0] && !i_d0_oe_n) o_dq[0] = i_d0;
    else if (!fe[0] && i_pullup) o_dq[0] = 1'h1;
  end

  // Sticky: both ends driving data0 at once
  always @(fe, i_d0_oe_n) begin
    if (fe[0] && !i_d0_oe_n) o_clash = 1'h1;
  end

  always @(posedge i_sclk or posedge i_sel_n) begin
    if (i_sel_n) begin
      cnt = 0;
      fe = 4'h0;
    end else begin
      if (cnt == 0) begin
        o_nbits = 0;
        o_addr = 32'h0;
      end
      if (!i_d0_oe_n) o_nbits++;
      if (cnt < 8) o_op = {o_op[6:0], i_d0};
      else if (cnt < 8 + ab) o_addr = {o_addr[30:0], i_d0};
      if (cnt == 7) begin
        ab = (o_op[3:0] == 4'hC) ? 32 : 24;
        w = (o_op[7:4] == 4'h6) ? 4 : (o_op[7:4] == 4'h3) ? 2 : 1;
      end
      if (cnt == 7 + ab) begin
        ca = o_addr;
        bi = 0;
        o_loads++;
      end
      cnt++;
    end
  end

  // Data changes only on the falling clock after the 8 dummy clocks
  always @(negedge i_sclk) begin
    if (!i_sel_n && cnt >= 16 + ab) begin
      if (bi == 0) cur = mem(ca);
      fe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h2;
      if (w == 1) fq[1] = cur[7 - bi];
      else if (w == 2) fq[1:0] = {cur[7 - bi], cur[6 - bi]};
      else fq = (bi == 0) ? cur[7:4] : cur[3:0];
      bi = (bi + w) % 8;
      if (bi == 0) ca++;
    end
  end
endmodule // sfc_flash_model
`default_nettype wire

// ### tb/tb_sfc_flash_loader.sv
/*
  Self-checking bench of the serial-flash loader: opcode table, width
  switches, clock rates, capture edge, release of data0 and shutdown.
  Assumes the flash model in sfc_flash_model.sv.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sfc_map.svh"
module tb_sfc_flash_loader;
  typedef struct packed {
    logic                wide;
    sfc_pkg::sfc_width_t w;
    logic [7:0]          op;
  } sfc_row_t;

  logic                core_clk = 1'h0;
  logic                ext_clk = 1'h0;
  logic                srst = 1'h1;
  logic                strap_n = 1'h1;
  logic                wide_opt = 1'h0;
  logic                cfg_done = 1'h0;
  sfc_pkg::sfc_cmd_t   cmd = '0;
  sfc_pkg::sfc_flash_t flash;
  sfc_pkg::sfc_byte_t  obyte;
  logic                chain_en;
  logic                chain_d;
  logic [3:0]          dq;
  logic [7:0]          m_op;
  logic [31:0]         m_addr;
  int                  m_loads;
  int                  m_nbits;
  logic                m_clash;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  int                  base = 0;
  int                  n = 0;
  logic [7:0]          got_q [$];
  sfc_row_t            rows [6] = '{
    '{1'h0, sfc_pkg::W_X1, `SFC_OP_FAST_X1},
    '{1'h0, sfc_pkg::W_X2, `SFC_OP_FAST_X2},
    '{1'h0, sfc_pkg::W_X4, `SFC_OP_FAST_X4},
    '{1'h1, sfc_pkg::W_X1, `SFC_OP_FAST_X1_W},
    '{1'h1, sfc_pkg::W_X2, `SFC_OP_FAST_X2_W},
    '{1'h1, sfc_pkg::W_X4, `SFC_OP_FAST_X4_W}};

  always #5 core_clk = ~core_clk;
  always #62.5 ext_clk = ~ext_clk;

  sfc_flash_loader u_dut (
    .i_core_clk(core_clk),
    .i_srst(srst),
    .i_external_master_clk_in(ext_clk),
    .i_flash_dq(dq),
    .i_config_pullup_strap_n(strap_n),
    .i_wide_address_option(wide_opt),
    .i_cmd(cmd),
    .i_cfg_done(cfg_done),
    .o_flash(flash),
    .o_byte(obyte),
    .o_chain_data(chain_d),
    .o_chain_en(chain_en)
  );

  sfc_flash_model u_flash (
    .i_sclk(flash.config_serial_clk),
    .i_sel_n(flash.flash_select_n),
    .i_d0(flash.data0_out_line),
    .i_d0_oe_n(flash.data0_oe_n),
    .i_pullup(flash.data0_pullup),
    .o_dq(dq),
    .o_op(m_op),
    .o_addr(m_addr),
    .o_loads(m_loads),
    .o_nbits(m_nbits),
    .o_clash(m_clash)
  );

  always @(posedge core_clk) begin
    if (obyte.vld === 1'h1) got_q.push_back(obyte.data);
  end

  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic give_up(input string nm);
    bad_count++;
    $display("[ERR] %s expected progress seen timeout", nm);
    final_report();
  endtask

  // Two external clock edges must land inside reset, hence 30 cycles
  task automatic do_reset(input logic w_opt, input logic s_n);
    @(negedge core_clk);
    srst = 1'h1;
    wide_opt = w_opt;
    strap_n = s_n;
    repeat (30) @(negedge core_clk);
    chk("sclk_rst", 32'h0, flash.config_serial_clk);
    chk("sel_rst", 32'h1, flash.flash_select_n);
    chk("oe_rst", 32'h1, flash.data0_oe_n);
    srst = 1'h0;
    got_q.delete();
    base = m_loads;
  endtask

  task automatic strobe(input logic wv, input sfc_pkg::sfc_width_t w,
                        input logic f, input logic e, input logic rv,
                        input logic [7:0] r);
    @(negedge core_clk);
    cmd = '{wv, w, f, e, rv, r};
    @(negedge core_clk);
    cmd = '0;
  endtask

  task automatic wait_load(input int k);
    int t;
    t = 0;
    while (m_loads < k) begin
      @(negedge core_clk);
      t++;
      if (t > 20000) give_up("load");
    end
  endtask

  task automatic chk_bytes(input int cnt);
    int t;
    t = 0;
    while (got_q.size() < cnt) begin
      @(negedge core_clk);
      t++;
      if (t > 40000) give_up("byte");
    end
    for (int k = 0; k < cnt; k++) begin
      chk("byte", 32'(8'(k) ^ 8'h5A), 32'(got_q[k]));
    end
  endtask

  // Half period of the serial clock in core cycles
  task automatic meas(output int h);
    logic s;
    int   t;
    t = 0;
    h = 0;
    @(negedge core_clk);
    s = flash.config_serial_clk;
    while (flash.config_serial_clk === s && t < 500) begin
      @(negedge core_clk);
      t++;
    end
    s = flash.config_serial_clk;
    while (flash.config_serial_clk === s && h < 500) begin
      @(negedge core_clk);
      h++;
    end
  endtask

  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].wide, 1'(i % 2));
      wait_load(base + 1);
      chk("op1", rows[i].wide ? `SFC_OP_FAST_X1_W : `SFC_OP_FAST_X1,
          m_op);
      chk("addr1", 32'h0, m_addr);
      chk_bytes(1);
      chk("nbits", rows[i].wide ? 40 : 32, m_nbits);
      chk("oe_rel", 32'h1, flash.data0_oe_n);
      chk("pullup", 32'(i % 2 == 0), flash.data0_pullup);
      chk("chain1", 32'h1, chain_en);
      if (rows[i].w != sfc_pkg::W_X1) begin
        strobe(1'h1, rows[i].w, 1'h0, 1'h0, 1'h0, 8'h00);
        wait_load(base + 2);
        chk("op2", rows[i].op, m_op);
        chk("addr2", 32'h2, m_addr);
      end
      chk_bytes(5);
      chk("chain2", 32'(rows[i].w == sfc_pkg::W_X1), chain_en);
    end
    // Rate set early is held back until the read is under way
    do_reset(1'h0, 1'h1);
    strobe(1'h0, sfc_pkg::W_X1, 1'h1, 1'h0, 1'h0, 8'h00);
    strobe(1'h0, sfc_pkg::W_X1, 1'h0, 1'h0, 1'h1, 8'h08);
    meas(n);
    chk("half_boot", 32'(`SFC_BOOT_HALF), n);
    chk_bytes(2);
    chk("chain_d1", 32'h1, chain_d);
    meas(n);
    chk("half_rate", 32'h8, n);
    chk_bytes(4);
    // External source: one half period per external period of 125 ns
    do_reset(1'h0, 1'h0);
    strobe(1'h0, sfc_pkg::W_X1, 1'h1, 1'h0, 1'h0, 8'h00);
    strobe(1'h0, sfc_pkg::W_X1, 1'h0, 1'h1, 1'h0, 8'h00);
    chk_bytes(1);
    chk("chain_d0", 32'h0, chain_d);
    meas(n);
    chk("half_ext", 32'h1, 32'(n == 12 || n == 13));
    chk_bytes(3);
    @(negedge core_clk);
    cfg_done = 1'h1;
    repeat (4) @(negedge core_clk);
    chk("sel_done", 32'h1, flash.flash_select_n);
    chk("clash", 32'h0, m_clash);
    final_report();
  end
endmodule // tb_sfc_flash_loader
`default_nettype wire
